// File: shs_irq.sv
`default_nettype none
module shs_irq (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] evtIn,
  input wire logic clrEn,
  input wire logic [3:0] clrBits,
  input wire logic maskEn,
  input wire logic [3:0] maskData,
  output logic [3:0] statusQ,
  output logic [3:0] maskQ,
  output logic irq
);
  logic [3:0] status_ff;
  logic [3:0] mask_ff;

  // Sticky status: a new event wins over write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      status_ff <= shs_pkg::EVT_ZERO;
    end else begin
      status_ff <= evtIn | (status_ff & ~(clrEn ? clrBits : shs_pkg::EVT_ZERO));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mask_ff <= shs_pkg::EVT_ZERO;
    end else if (maskEn) begin
      mask_ff <= maskData;
    end
  end

  assign statusQ = status_ff;
  assign maskQ = mask_ff;
  assign irq = |(status_ff & mask_ff);

  evt_sticky_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    evtIn[0] |=> statusQ[0])
    else $error("event not captured");
endmodule // shs_irq
`default_nettype wire

// File: shs_pkg.sv
`default_nettype none
package shs_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_STATE = 12'h000;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
  localparam logic [31:0] STATE_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Writable bits of the state register; all others read zero
  localparam logic [31:0] STATE_WMASK = 32'h0007_fd8b;
  // Bit positions of the state register
  localparam int BIT_MEM_ACT = 0;
  localparam int BIT_BUS_ACT = 1;
  localparam int BIT_USG_ACT = 3;
  localparam int BIT_SVC_ACT = 7;
  localparam int BIT_MON_ACT = 8;
  localparam int BIT_PSV_ACT = 10;
  localparam int BIT_TCK_ACT = 11;
  localparam int BIT_USG_PEND = 12;
  localparam int BIT_MEM_PEND = 13;
  localparam int BIT_BUS_PEND = 14;
  localparam int BIT_SVC_PEND = 15;
  localparam int BIT_MEM_ENA = 16;
  localparam int BIT_BUS_ENA = 17;
  localparam int BIT_USG_ENA = 18;
  localparam int NUM_EVT = 4;
  localparam logic [NUM_EVT-1:0] EVT_ZERO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Per-bit hardware update from the exception core: set and clear strobes
  typedef struct packed {
    logic [31:0] set;
    logic [31:0] clr;
  } shs_hwupd_s;

  // Decoded software write toward the state register
  typedef struct packed {
    logic en;
    logic [31:0] data;
    logic [3:0] strb;
  } shs_swwr_s;
endpackage
`default_nettype wire

// File: shs_state_reg.sv
`default_nettype none
module shs_state_reg (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire shs_pkg::shs_swwr_s swWr,
  input wire shs_pkg::shs_hwupd_s hwUpd,
  output logic [31:0] stateQ
);
  logic [31:0] state_ff;
  logic [31:0] byteMask;

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      byteMask[i] = swWr.strb[i/8];
    end
  end

  // ---------------------------------------------------------------
  // Per-bit storage: hardware set beats any clear, software or hardware
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : gBit
      if (shs_pkg::STATE_WMASK[g]) begin : gRw
        always_ff @(posedge ref_clk) begin
          if (!rstn) begin
            state_ff[g] <= shs_pkg::STATE_RESET[g];
          end else if (hwUpd.set[g]) begin
            state_ff[g] <= 1'b1;
          end else if (swWr.en && byteMask[g]) begin
            // Active, pended and enable bits all take the written value
            state_ff[g] <= swWr.data[g];
          end else if (hwUpd.clr[g]) begin
            state_ff[g] <= 1'b0;
          end
        end
      end else begin : gRo
        always_ff @(posedge ref_clk) begin
          state_ff[g] <= shs_pkg::STATE_RESET[g];
        end
      end
    end
  endgenerate

  assign stateQ = state_ff & shs_pkg::STATE_WMASK;

  // Checks the storage itself, since the read path masks reserved bits anyway
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_ff & ~shs_pkg::STATE_WMASK) == shs_pkg::ZERO_WORD)
    else $error("reserved state bit stored nonzero");
  reset_clear_a: assert property (@(posedge ref_clk)
    !rstn |=> stateQ == shs_pkg::STATE_RESET)
    else $error("state not cleared by reset");
  hw_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_MEM_PEND] |=> stateQ[shs_pkg::BIT_MEM_PEND])
    else $error("pend set lost");
endmodule // shs_state_reg
`default_nettype wire

// File: shs_top.sv
// Implementation choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
// Behaviour
// - Bit 0 shows memory management handler active; software read/write.
// - Bit 1 shows bus fault handler active; software read/write.
// - Bit 3 shows usage fault handler active; software read/write.
// - Bit 7 shows SVCall handler active; software read/write.
// - Bit 8 shows debug monitor handler active; software read/write.
// - Bit 10 shows PendSV handler active; software read/write.
// - Bit 11 shows SysTick handler active; software read/write.
// - Bit 12 shows usage fault pending; software read/write.
// - Bit 13 shows memory management fault pending; software read/write.
// - Bit 14 shows bus fault pending; software read/write.
// - Bit 15 shows SVCall pending; software read/write.
// - Bit 16 enables memory management fault exception.
// - Bit 17 enables bus fault exception.
// - Bit 18 enables usage fault exception.
module shs_top (
  input wire logic ref_clk,
  input wire logic rstn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Exception core side
  input wire shs_pkg::shs_hwupd_s hwUpd,
  output logic memFaultEn,
  output logic busFaultEn,
  output logic usgFaultEn,
  output logic irq
);
  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic awHeld_ff;
  logic wHeld_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wrFire;
  logic [31:0] stateQ;
  logic [3:0] statusQ;
  logic [3:0] maskQ;
  logic [3:0] pendEvt;
  logic [31:0] setIn;
  shs_pkg::shs_swwr_s swWr;

  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready = !wHeld_ff && !bvalid_ff;
  assign wrFire = awHeld_ff && wHeld_ff && !bvalid_ff;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awHeld_ff <= 1'b0;
      awaddr_ff <= shs_pkg::ADDR_STATE;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wHeld_ff <= 1'b0;
      wdata_ff <= shs_pkg::ZERO_WORD;
      wstrb_ff <= shs_pkg::EVT_ZERO;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= shs_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == shs_pkg::ADDR_STATE || awaddr_ff == shs_pkg::ADDR_IRQ_STATUS ||
                   awaddr_ff == shs_pkg::ADDR_IRQ_MASK) ? shs_pkg::RESP_OKAY
                                                        : shs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_comb begin
    swWr.en = wrFire && awaddr_ff == shs_pkg::ADDR_STATE;
    swWr.data = wdata_ff;
    swWr.strb = wstrb_ff;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Software may rewrite active flags freely; no stack repair is attempted here
  shs_state_reg u_state (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .swWr(swWr),
    .hwUpd(hwUpd),
    .stateQ(stateQ)
  );

  assign memFaultEn = stateQ[shs_pkg::BIT_MEM_ENA];
  assign busFaultEn = stateQ[shs_pkg::BIT_BUS_ENA];
  assign usgFaultEn = stateQ[shs_pkg::BIT_USG_ENA];

  // ---------------------------------------------------------------
  // Interrupt on newly pended faults and SVCall
  // ---------------------------------------------------------------
  assign setIn = hwUpd.set;
  assign pendEvt = {setIn[shs_pkg::BIT_SVC_PEND], setIn[shs_pkg::BIT_BUS_PEND],
                    setIn[shs_pkg::BIT_MEM_PEND], setIn[shs_pkg::BIT_USG_PEND]};

  shs_irq u_irq (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .evtIn(pendEvt),
    .clrEn(wrFire && awaddr_ff == shs_pkg::ADDR_IRQ_STATUS),
    .clrBits(wdata_ff[3:0]),
    .maskEn(wrFire && awaddr_ff == shs_pkg::ADDR_IRQ_MASK && wstrb_ff[0]),
    .maskData(wdata_ff[3:0]),
    .statusQ(statusQ),
    .maskQ(maskQ),
    .irq(irq)
  );

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= shs_pkg::ZERO_WORD;
      rresp_ff <= shs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= shs_pkg::RESP_OKAY;
      case (s_axi_araddr)
        shs_pkg::ADDR_STATE: begin
          rdata_ff <= stateQ;
        end
        shs_pkg::ADDR_IRQ_STATUS: begin
          rdata_ff <= {28'h0000000, statusQ};
        end
        shs_pkg::ADDR_IRQ_MASK: begin
          rdata_ff <= {28'h0000000, maskQ};
        end
        default: begin
          rdata_ff <= shs_pkg::ZERO_WORD;
          rresp_ff <= shs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sw_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    swWr.en && swWr.strb[0] && !hwUpd.set[shs_pkg::BIT_MEM_ACT]
    |=> stateQ[shs_pkg::BIT_MEM_ACT] == $past(wdata_ff[shs_pkg::BIT_MEM_ACT]))
    else $error("mem act write not stored");
  bus_act_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    swWr.en && swWr.strb[0] && !hwUpd.set[shs_pkg::BIT_BUS_ACT]
    |=> stateQ[shs_pkg::BIT_BUS_ACT] == $past(wdata_ff[shs_pkg::BIT_BUS_ACT]))
    else $error("bus act write not stored");
  usg_act_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_USG_ACT] |=> stateQ[shs_pkg::BIT_USG_ACT])
    else $error("usage act not set");
  svc_act_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_SVC_ACT] |=> stateQ[shs_pkg::BIT_SVC_ACT])
    else $error("svcall act not set");
  mon_act_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_MON_ACT] |=> stateQ[shs_pkg::BIT_MON_ACT])
    else $error("monitor act not set");
  psv_act_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_PSV_ACT] |=> stateQ[shs_pkg::BIT_PSV_ACT])
    else $error("pendsv act not set");
  tck_act_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_TCK_ACT] |=> stateQ[shs_pkg::BIT_TCK_ACT])
    else $error("systick act not set");
  usg_pend_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_USG_PEND] |=> stateQ[shs_pkg::BIT_USG_PEND])
    else $error("usage pend not set");
  // Other pended sources may hold the interrupt up, so only the masked-in case is tied down
  bus_pend_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_BUS_PEND]
    |=> stateQ[shs_pkg::BIT_BUS_PEND] && statusQ[2] && (irq || !maskQ[2]))
    else $error("bus pend not set");
  svc_pend_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwUpd.set[shs_pkg::BIT_SVC_PEND] |=> stateQ[shs_pkg::BIT_SVC_PEND] && statusQ[3])
    else $error("svcall pend not set");
  mem_ena_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    swWr.en && swWr.strb[2] && !hwUpd.set[shs_pkg::BIT_MEM_ENA]
    |=> memFaultEn == $past(swWr.data[shs_pkg::BIT_MEM_ENA]))
    else $error("mem fault enable not written");
  bus_ena_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    swWr.en && swWr.strb[2] && !hwUpd.set[shs_pkg::BIT_BUS_ENA]
    |=> busFaultEn == $past(swWr.data[shs_pkg::BIT_BUS_ENA]))
    else $error("bus fault enable not written");
  usg_ena_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    swWr.en && swWr.strb[2] && !hwUpd.set[shs_pkg::BIT_USG_ENA]
    |=> usgFaultEn == $past(swWr.data[shs_pkg::BIT_USG_ENA]))
    else $error("usage fault enable not written");
endmodule // shs_top
`default_nettype wire

// File: tb_top.sv
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %0t %s", $time, m); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] awAddr = 12'h000;
  logic awValid = 1'b0;
  logic [31:0] wData = 32'h0000_0000;
  logic [3:0] wStrb = 4'h0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic [11:0] arAddr = 12'h000;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  shs_pkg::shs_hwupd_s hw = '0;
  logic awReady, wReady, bValid, arReady, rValid, memEn, busEn, usgEn, irq;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h124a;
  logic [31:0] expState = 32'h0000_0000;
  logic [31:0] rd, t1, t2;
  logic [1:0] rsp;

  shs_top DUT (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .hwUpd(hw), .memFaultEn(memEn), .busFaultEn(busEn),
    .usgFaultEn(usgEn), .irq(irq));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] swMerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & shs_pkg::STATE_WMASK;
    return (o & ~bm) | (d & bm);
  endfunction

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  // Handshakes are sampled at the falling edge: inputs and registered
  // state are stable there, so the rising edge that follows sees the same
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
    logic aHit, wHit, bHit;
    int n;
    n = 0;
    bHit = 1'b0;
    r = 2'b11;
    @(posedge ref_clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wStrb <= s;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!bHit && n < 50) begin
      @(negedge ref_clk);
      aHit = awValid && awReady;
      wHit = wValid && wReady;
      bHit = bReady && bValid;
      if (bHit) r = bResp;
      @(posedge ref_clk);
      if (aHit) awValid <= 1'b0;
      if (wHit) wValid <= 1'b0;
      if (bHit) bReady <= 1'b0;
      n++;
    end
    if (!bHit) begin
      mismatches++;
      $display("FAIL %0t write answer timeout", $time);
      finish_test();
    end
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic aHit, rHit;
    int n;
    n = 0;
    rHit = 1'b0;
    r = 2'b11;
    d = 32'h0;
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (!rHit && n < 50) begin
      @(negedge ref_clk);
      aHit = arValid && arReady;
      rHit = rReady && rValid;
      if (rHit) d = rData;
      if (rHit) r = rResp;
      @(posedge ref_clk);
      if (aHit) arValid <= 1'b0;
      if (rHit) rReady <= 1'b0;
      n++;
    end
    if (!rHit) begin
      mismatches++;
      $display("FAIL %0t read answer timeout", $time);
      finish_test();
    end
  endtask

  task automatic writeState(input logic [31:0] d, input logic [3:0] s);
    axiWrite(shs_pkg::ADDR_STATE, d, s, rsp);
    `CHK(rsp, shs_pkg::RESP_OKAY, "state write resp")
    expState = swMerge(expState, d, s);
  endtask

  task automatic checkState();
    axiRead(shs_pkg::ADDR_STATE, rd, rsp);
    `CHK(rsp, shs_pkg::RESP_OKAY, "state read resp")
    `CHK(rd, expState, "state readback")
    @(negedge ref_clk);
    `CHK({usgEn, busEn, memEn}, expState[18:16], "fault enables")
  endtask

  // Set beats clear when both strobes hit one bit
  task automatic hwPulse(input logic [31:0] s, input logic [31:0] c);
    @(posedge ref_clk);
    hw <= '{set: s, clr: c};
    @(posedge ref_clk);
    hw <= '0;
    expState = ((expState & ~c) | s) & shs_pkg::STATE_WMASK;
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    checkState();
    writeState(32'hffff_ffff, 4'hf);
    checkState();
    for (int i = 0; i < 32; i++) begin
      writeState(32'h0, 4'hf);
      hwPulse(32'h1 << i, 32'h0);
      checkState();
      hwPulse(32'h1 << i, 32'h1 << i);
      hwPulse(32'h0, 32'h1 << i);
      checkState();
    end
    for (int k = 0; k < 40; k++) begin
      t1 = rnd();
      t2 = rnd();
      if (rnd() & 32'h1) writeState(t1, t2[3:0]);
      else hwPulse(t1, t2);
      checkState();
    end
    // Unmapped word: error answer, no side effect
    axiWrite(12'h00c, 32'hffff_ffff, 4'hf, rsp);
    `CHK(rsp, shs_pkg::RESP_SLVERR, "unmapped write")
    axiRead(12'h00c, rd, rsp);
    `CHK(rsp, shs_pkg::RESP_SLVERR, "unmapped read")
    `CHK(rd, shs_pkg::ZERO_WORD, "unmapped data")
    checkState();
    // Pend events: raise, mask, clear
    axiWrite(shs_pkg::ADDR_IRQ_STATUS, 32'hf, 4'hf, rsp);
    axiWrite(shs_pkg::ADDR_IRQ_MASK, 32'h2, 4'h1, rsp);
    hwPulse(32'h0000_2000, 32'h0);
    settle();
    `CHK(irq, 1'b1, "irq raise")
    axiRead(shs_pkg::ADDR_IRQ_STATUS, rd, rsp);
    `CHK(rd, 32'h0000_0002, "irq status")
    hwPulse(32'h0000_8000, 32'h0);
    axiWrite(shs_pkg::ADDR_IRQ_STATUS, 32'h2, 4'hf, rsp);
    settle();
    `CHK(irq, 1'b0, "irq masked")
    axiRead(shs_pkg::ADDR_IRQ_STATUS, rd, rsp);
    `CHK(rd, 32'h0000_0008, "irq status masked")
    axiWrite(shs_pkg::ADDR_IRQ_MASK, 32'h8, 4'h1, rsp);
    axiRead(shs_pkg::ADDR_IRQ_MASK, rd, rsp);
    `CHK(rd, 32'h0000_0008, "mask readback")
    settle();
    `CHK(irq, 1'b1, "irq unmasked")
    axiWrite(shs_pkg::ADDR_IRQ_STATUS, 32'h8, 4'hf, rsp);
    settle();
    `CHK(irq, 1'b0, "irq cleared")
    // Reset in mid-run
    writeState(32'hffff_ffff, 4'hf);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    expState = shs_pkg::STATE_RESET;
    checkState();
    finish_test();
  end

  // Whole run needs about a thousand cycles; this leaves ample margin
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
